// >>> logic/adc_ctl_pkg.sv
/*
 package for the converter timing and format control block: register
 offsets, field positions, reset values and timing counts.
 assumes a 32-bit classic wishbone slave with word offsets.
*/
package adc_ctl_pkg;
    localparam logic [3:0] OFS_TIMING  = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_RESULT  = 4'h8;
    localparam logic [3:0] OFS_STATUS  = 4'hC;
    localparam logic [4:0] OFS_MASK    = 5'h10;

    localparam int JUSTIFY_BIT = 7;
    localparam int UNUSED_BIT  = 6;
    localparam int ACQ_LSB     = 3;
    localparam int CLK_LSB     = 0;
    localparam int START_BIT   = 0;
    localparam int PORT_CFG_LSB = 4;

    localparam logic [7:0] TIMING_RESET     = 8'h00;
    localparam logic [3:0] PORT_CFG_ANALOG  = 4'h0;
    localparam logic [3:0] PORT_CFG_DIGITAL = 4'h7;
    localparam logic [7:0] TIMING_WMASK     = 8'hBF;

    // instruction cycle is four oscillator cycles
    localparam int CLK_HZ          = 40000000;
    localparam int INSTR_CYCLE_NS  = 100;
    localparam int INSTR_CYCLES    =
        (INSTR_CYCLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int RC_HALF_PERIOD  = 40;
    localparam int CONV_BITS       = 10;
    localparam int CONV_TICKS      = 11;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DELAY  = 2'b01,
        ST_ACQ    = 2'b10,
        ST_CONV   = 2'b11
    } conv_state_e;
endpackage

// >>> logic/adc_timing_format_control.sv
/*
 timing and format control for an analog-to-digital converter: holds the
 timing register, makes the conversion clock enable, sequences acquisition
 and conversion, formats the result, raises the done interrupt.
 assumes a classic wishbone master on sys_clk and an analog core that
 returns a 10-bit sample and takes hold/sample strobes.
*/
// The register addresses and the Wishbone interface to the registers were left to the implementer.
// Functional notes
// - at reset port config is 0000 with the strap high, else 0111.
// - timing bit 7 right-justifies the result when 1, left when 0.
// - timing bit 6 ignores writes and reads zero.
// - bits 5:3 pick 20,16,12,8,6,4,2 or 0 clock periods of acquisition.
// - clock codes 101,100,001,000 divide the oscillator by 16,4,8,2.
// - clock codes 111 and 011 pick the internal rc conversion clock.
// - with the rc clock one instruction cycle passes before it runs.
// - after start, sample for the acquisition time, then convert.
// - at the end the result loads, start clears and the done flag sets.
`timescale 1ns/10ps
module adc_timing_format_control (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        analog_on_reset_cfg,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [9:0]  sample_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [3:0]  port_analog_config,
    output logic             sampling,
    output logic             conv_tick,
    output logic             irq
);
    // full period in sys_clk cycles; 7 bits so divide by 64 and rc fit
    function automatic logic [6:0] div_period(input logic [2:0] code);
        unique case (code)
            3'b000: div_period = 7'h02;
            3'b001: div_period = 7'h08;
            3'b010: div_period = 7'h20;
            3'b100: div_period = 7'h04;
            3'b101: div_period = 7'h10;
            3'b110: div_period = 7'h40;
            default: div_period = 7'(2 * adc_ctl_pkg::RC_HALF_PERIOD);
        endcase
    endfunction

    function automatic logic [4:0] acq_periods(input logic [2:0] code);
        unique case (code)
            3'b111: acq_periods = 5'd20;
            3'b110: acq_periods = 5'd16;
            3'b101: acq_periods = 5'd12;
            3'b100: acq_periods = 5'd8;
            3'b011: acq_periods = 5'd6;
            3'b010: acq_periods = 5'd4;
            3'b001: acq_periods = 5'd2;
            default: acq_periods = 5'd0;
        endcase
    endfunction

    adc_ctl_pkg::conv_state_e state, next_state;
    logic [7:0]  timing, next_timing;
    logic [3:0]  port_cfg, next_port_cfg;
    logic        cfg_loaded, next_cfg_loaded;
    logic        strap_s1, strap_s2;
    logic [1:0]  sync_fill;
    logic        start, next_start;
    logic        done_flag, next_done_flag;
    logic        done_mask, next_done_mask;
    logic [15:0] result, next_result;
    logic [6:0]  div_cnt, next_div_cnt;
    logic        tick, next_tick;
    logic [4:0]  seq_cnt, next_seq_cnt;
    logic [31:0] rdata, next_rdata;
    logic        ack, next_ack;
    logic        rc_sel;
    logic        wr, rd;
    logic        done_evt;
    logic        adr_ok;

    assign rc_sel = (timing[2:0] == 3'b111) || (timing[2:0] == 3'b011);
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !ack;
    // full decode: no aliases above the register window
    assign adr_ok = (wb_adr_i[31:5] == 27'h0);

    always_comb begin
        next_timing      = timing;
        next_port_cfg    = port_cfg;
        next_cfg_loaded  = cfg_loaded || sync_fill[1];
        next_start       = start;
        next_done_flag   = done_flag;
        next_done_mask   = done_mask;
        next_result      = result;
        next_div_cnt     = div_cnt;
        next_tick        = 1'b0;
        next_seq_cnt     = seq_cnt;
        next_state       = state;
        next_ack         = rd;
        next_rdata       = 32'h0000_0000;
        done_evt         = 1'b0;
        // strap trusted only once both sync stages hold it
        if (!cfg_loaded && sync_fill[1]) begin
            next_port_cfg = strap_s2 ? adc_ctl_pkg::PORT_CFG_ANALOG
                                     : adc_ctl_pkg::PORT_CFG_DIGITAL;
        end
        // conversion clock enable, halted while idle and during the rc delay
        if (state == adc_ctl_pkg::ST_IDLE
            || state == adc_ctl_pkg::ST_DELAY) begin
            next_div_cnt = 7'h00;
        end else if (div_cnt + 7'h01
                     >= div_period(timing[adc_ctl_pkg::CLK_LSB +: 3])) begin
            next_div_cnt = 7'h00;
            next_tick = 1'b1;
        end else begin
            next_div_cnt = div_cnt + 7'h01;
        end
        unique case (state)
            adc_ctl_pkg::ST_IDLE: begin
                if (start) begin
                    next_seq_cnt = 5'd0;
                    next_state = rc_sel ? adc_ctl_pkg::ST_DELAY
                                        : adc_ctl_pkg::ST_ACQ;
                end
            end
            adc_ctl_pkg::ST_DELAY: begin
                if (seq_cnt + 5'd1 >= 5'(adc_ctl_pkg::INSTR_CYCLES)) begin
                    next_seq_cnt = 5'd0;
                    next_state = adc_ctl_pkg::ST_ACQ;
                end else begin
                    next_seq_cnt = seq_cnt + 5'd1;
                end
            end
            adc_ctl_pkg::ST_ACQ: begin
                if (seq_cnt >= acq_periods(timing[5:3])) begin
                    next_seq_cnt = 5'd0;
                    next_state = adc_ctl_pkg::ST_CONV;
                end else if (tick) begin
                    next_seq_cnt = seq_cnt + 5'd1;
                end
            end
            adc_ctl_pkg::ST_CONV: begin
                if (tick) begin
                    next_seq_cnt = seq_cnt + 5'd1;
                end
                if (tick && seq_cnt + 5'd1 >= 5'(adc_ctl_pkg::CONV_TICKS)) begin
                    done_evt = 1'b1;
                    next_start = 1'b0;
                    next_state = adc_ctl_pkg::ST_IDLE;
                    next_result = timing[adc_ctl_pkg::JUSTIFY_BIT]
                        ? {6'h00, sample_i}
                        : {sample_i, 6'h00};
                end
            end
        endcase
        if (wr && adr_ok) begin
            if (wb_adr_i[4:0] == {1'b0, adc_ctl_pkg::OFS_TIMING}) begin
                next_timing = wb_dat_i[7:0] & adc_ctl_pkg::TIMING_WMASK;
            end
            if (wb_adr_i[4:0] == {1'b0, adc_ctl_pkg::OFS_CONTROL}) begin
                if (wb_dat_i[adc_ctl_pkg::START_BIT]) begin
                    next_start = 1'b1;
                end
                next_port_cfg = wb_dat_i[adc_ctl_pkg::PORT_CFG_LSB +: 4];
            end
            if (wb_adr_i[4:0] == {1'b0, adc_ctl_pkg::OFS_STATUS}
                && wb_dat_i[0]) begin
                next_done_flag = 1'b0;
            end
            if (wb_adr_i[4:0] == adc_ctl_pkg::OFS_MASK) begin
                next_done_mask = wb_dat_i[0];
            end
        end
        // set wins over a clear in the same cycle
        if (done_evt) begin
            next_done_flag = 1'b1;
        end
        if (rd && adr_ok) begin
            unique case (wb_adr_i[4:0])
                {1'b0, adc_ctl_pkg::OFS_TIMING}:
                    next_rdata = {24'h000000, timing & adc_ctl_pkg::TIMING_WMASK};
                {1'b0, adc_ctl_pkg::OFS_CONTROL}:
                    next_rdata = {24'h000000, port_cfg, 3'h0, start};
                {1'b0, adc_ctl_pkg::OFS_RESULT}:
                    next_rdata = {16'h0000, result};
                {1'b0, adc_ctl_pkg::OFS_STATUS}:
                    next_rdata = {31'h00000000, done_flag};
                adc_ctl_pkg::OFS_MASK:
                    next_rdata = {31'h00000000, done_mask};
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_s1  <= 1'b0;
            strap_s2  <= 1'b0;
            sync_fill <= 2'h0;
        end else begin
            strap_s1  <= analog_on_reset_cfg;
            strap_s2  <= strap_s1;
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= adc_ctl_pkg::ST_IDLE;
            timing      <= adc_ctl_pkg::TIMING_RESET;
            port_cfg    <= adc_ctl_pkg::PORT_CFG_DIGITAL;
            cfg_loaded  <= 1'b0;
            start       <= 1'b0;
            done_flag   <= 1'b0;
            done_mask   <= 1'b0;
            result      <= 16'h0000;
            div_cnt     <= 7'h00;
            tick        <= 1'b0;
            seq_cnt     <= 5'd0;
            rdata       <= 32'h0000_0000;
            ack         <= 1'b0;
            irq         <= 1'b0;
            sampling    <= 1'b0;
        end else begin
            state       <= next_state;
            timing      <= next_timing;
            port_cfg    <= next_port_cfg;
            cfg_loaded  <= next_cfg_loaded;
            start       <= next_start;
            done_flag   <= next_done_flag;
            done_mask   <= next_done_mask;
            result      <= next_result;
            div_cnt     <= next_div_cnt;
            tick        <= next_tick;
            seq_cnt     <= next_seq_cnt;
            rdata       <= next_rdata;
            ack         <= next_ack;
            irq         <= next_done_flag && next_done_mask;
            sampling    <= next_state != adc_ctl_pkg::ST_CONV;
        end
    end

    assign wb_dat_o = rdata;
    assign wb_ack_o = ack;
    assign port_analog_config = port_cfg;
    assign conv_tick = tick;

    chk_done_clears_start: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(done_flag) |-> !start || $past(wr))
        else $error("start not cleared");
    chk_rc_delay_path: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == adc_ctl_pkg::ST_IDLE && start && rc_sel)
        |=> state == adc_ctl_pkg::ST_DELAY) else $error("rc delay skipped");
    chk_bit6_zero: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !timing[adc_ctl_pkg::UNUSED_BIT]) else $error("bit 6 set");
    chk_no_acq_zero: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == adc_ctl_pkg::ST_ACQ && timing[5:3] == 3'b000)
        |=> state == adc_ctl_pkg::ST_CONV) else $error("zero acq waited");
    chk_div2_tick: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (tick && timing[2:0] == 3'b000 && $stable(timing)
         && state == adc_ctl_pkg::ST_CONV && !done_evt)
        |=> !tick ##1 tick) else $error("div2 period wrong");
    chk_port_cfg_strap: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (!cfg_loaded && sync_fill[1]) |=> port_cfg == ($past(strap_s2)
            ? adc_ctl_pkg::PORT_CFG_ANALOG : adc_ctl_pkg::PORT_CFG_DIGITAL)
            || $past(wr)) else $error("strap load wrong");
    chk_justify_right: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (done_evt && timing[7]) |=> result == {6'h00, $past(sample_i)})
        else $error("right justify wrong");
    chk_acq_before_conv: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(state == adc_ctl_pkg::ST_CONV)
        |-> $past(state) == adc_ctl_pkg::ST_ACQ)
        else $error("conv without acq");
    cov_rc_conv: cover property (@(posedge sys_clk) disable iff (!arst_n)
        state == adc_ctl_pkg::ST_DELAY ##[1:20] state == adc_ctl_pkg::ST_ACQ);
    cov_done: cover property (@(posedge sys_clk) disable iff (!arst_n)
        done_evt);
    cov_irq: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(irq));
endmodule // adc_timing_format_control

// >>> tb/analog_core_model.sv
/*
 stand-in for the sample-and-hold and converter core.
 assumes sampling low means the input is held and being converted.
*/
`timescale 1ns/10ps
module analog_core_model (
    input  wire logic       sys_clk,
    input  wire logic       sampling,
    input  wire logic [9:0] level,
    output logic      [9:0] sample_i
);
    logic [9:0] held = '0;
    logic       late = 1'b0;
    always_ff @(posedge sys_clk) begin
        late <= ~sampling;
        if (sampling) begin
            held <= level;
        end
    end
    // valid while held and one cycle after; inverted otherwise so stale reads show up
    assign sample_i = (~sampling | late) ? held : ~held;
endmodule // analog_core_model

// >>> tb/adc_timing_format_control_test.sv
/*
 self-checking bench for the converter timing and format control block.
 assumes a wishbone answer within 19 cycles and the offsets of the package.
*/
`timescale 1ns/10ps
module adc_timing_format_control_test;
    logic        sys_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        strap   = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, tick, smp, irq;
    logic [31:0] adr = '0, wdat = '0, dat_o, q;
    logic [9:0]  level = '0, sample;
    logic [3:0]  port_cfg;
    int          failures = 0, total_checks = 0;
    localparam int CLKC[8] = '{0, 4, 1, 5, 2, 6, 7, 3};
    localparam int DIVS[8] = '{2, 4, 8, 16, 32, 64,
        2 * adc_ctl_pkg::RC_HALF_PERIOD, 2 * adc_ctl_pkg::RC_HALF_PERIOD};
    localparam int ACQS[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    always #12.5 sys_clk = ~sys_clk;

    adc_timing_format_control dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .analog_on_reset_cfg(strap), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .sample_i(sample), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .port_analog_config(port_cfg), .sampling(smp), .conv_tick(tick),
        .irq(irq));
    analog_core_model core (.sys_clk(sys_clk), .sampling(smp),
        .level(level), .sample_i(sample));

    task automatic give_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // no fixed latency assumed: wait for ack under a bound
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k >= 20) begin
            failures++;
            give_verdict();
        end
    endtask

    task automatic reset_with(input logic s, input logic [3:0] exp);
        @(posedge sys_clk);
        strap <= s;
        arst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check(port_cfg, exp);
        wb(1'b0, 32'(adc_ctl_pkg::OFS_CONTROL), 0);
        check(q[7:4], exp);
        $display("reset test done, strap %0d", s);
    endtask

    task automatic reg_test;
        wb(1'b1, 32'(adc_ctl_pkg::OFS_TIMING), 32'hFF);
        wb(1'b0, 32'(adc_ctl_pkg::OFS_TIMING), 0);
        check(q, 32'hBF);
        wb(1'b1, 32'h20, 32'hFF);
        wb(1'b0, 32'h20, 0);
        check(q, 32'h0);
        $display("register test done");
    endtask

    task automatic conv(input int i);
        int n, acq, cv, last, gap, first;
        logic fell, fin;
        logic [9:0] v;
        v = 10'h2A5 ^ 10'(i);
        level <= v;
        wb(1'b1, 32'(adc_ctl_pkg::OFS_MASK), 32'(i != 7));
        wb(1'b1, 32'(adc_ctl_pkg::OFS_TIMING),
           {24'h0, i[0], 1'b0, i[2:0], CLKC[i][2:0]});
        wb(1'b1, 32'(adc_ctl_pkg::OFS_CONTROL), 32'h1);
        {n, acq, cv, last, gap, first, fell, fin} = '0;
        while (!fin && n < 6000) begin
            @(posedge sys_clk);
            #1;
            n++;
            fin = fell && smp;
            if (tick && !fin) begin
                if (smp) acq++;
                else cv++;
                if (last == 0) first = n;
                gap = n - last;
                last = n;
            end
            fell = fell | !smp;
        end
        if (!fin) begin
            failures++;
            give_verdict();
        end
        repeat (3) @(posedge sys_clk);
        check(acq, ACQS[i]);
        check(cv, adc_ctl_pkg::CONV_TICKS);
        check(gap, DIVS[i]);
        // rc codes start their clock one instruction cycle late
        check(first - DIVS[i], (i > 5) * adc_ctl_pkg::INSTR_CYCLES);
        wb(1'b0, 32'(adc_ctl_pkg::OFS_RESULT), 0);
        check(q, i[0] ? {22'h0, v} : {16'h0, v, 6'h00});
        wb(1'b0, 32'(adc_ctl_pkg::OFS_CONTROL), 0);
        check(q[0], 1'b0);
        wb(1'b0, 32'(adc_ctl_pkg::OFS_STATUS), 0);
        check(q[0], 1'b1);
        check(irq, i != 7);
        wb(1'b1, 32'(adc_ctl_pkg::OFS_STATUS), 32'h1);
        wb(1'b0, 32'(adc_ctl_pkg::OFS_STATUS), 0);
        check({q[0], irq}, 2'b00);
        $display("conversion test %0d done", i);
    endtask

    initial begin
        reset_with(1'b1, adc_ctl_pkg::PORT_CFG_ANALOG);
        reg_test();
        for (int i = 0; i < 8; i++) begin
            conv(i);
        end
        reset_with(1'b0, adc_ctl_pkg::PORT_CFG_DIGITAL);
        give_verdict();
    end
endmodule // adc_timing_format_control_test
